// File: lct_pkg.sv
// Shared constants for the loop cell transmit data path.
// Assumes a single 10 MHz system clock and an APB register bus.
package lct_pkg;

	// System clock rate and link clock figure
	localparam int CLK_HZ = 10_000_000;
	localparam int LINK_PERIOD_NS = 800;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] SLVADDR_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;

	// Control register field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MASTER_BIT = 1;
	localparam int CTRL_BYTE_MODE_BIT = 2;
	localparam int CTRL_ODD_PARITY_BIT = 3;
	localparam int CTRL_TWO_CELL_BIT = 4;

	// Reset values
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [5:0] SLVADDR_RESET = 6'h00;

	// Slave address compare width
	localparam int SLV_ADDR_WIDTH = 6;

	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

	// Transfer states, Gray along idle -> master send / slave drive
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MASTER_SEND = 2'b01,
		ST_SLAVE_DRIVE = 2'b10
	} lct_state_type;

endpackage

// File: lct_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain.
// Assumes the inputs are plain levels; no edge is detected here.
module lct_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// Both stages of the chain
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} lct_sync_state_type;

	lct_sync_state_type sync_ff;
	lct_sync_state_type nxt_sync;

	// First stage only feeds the second
	always_comb begin
		nxt_sync = sync_ff;
		nxt_sync.stage1 = async_in;
		nxt_sync.stage2 = sync_ff.stage1;
	end

	// Synchronous reset clears both stages
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			sync_ff <= '0;
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff.stage2;

endmodule

// File: lct_tx_datapath.sv
// Loop transmit data path: drives cell words, markers and parity onto the
// cell bus in master or slave mode, with an APB register slave.
// Assumes the link clock is much slower than clk_in (at least 4 clk per
// link period) and that the user side presents words of one cell back to back.

module lct_tx_datapath #(
	parameter int DATA_WIDTH = 16,
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// User-side cell word stream
	input wire logic [DATA_WIDTH-1:0] cell_word_in,
	input wire logic cell_valid_in,
	input wire logic cell_prepend_in,
	input wire logic cell_first_in,
	input wire logic cell_last_in,
	output logic cell_take_out,
	// Link pins
	input wire logic tx_interface_clock_in,
	input wire logic tx_enable_n_in,
	output logic tx_enable_n_out,
	output logic tx_enable_n_oe_out,
	input wire logic [ADDR_WIDTH-1:0] tx_poll_address_in,
	output logic tx_space_available_out,
	output logic tx_space_available_oe_out,
	output logic tx_transfer_start_mark_out,
	output logic tx_transfer_start_mark_oe_out,
	output logic tx_cell_start_mark_out,
	output logic tx_cell_start_mark_oe_out,
	output logic [DATA_WIDTH-1:0] tx_cell_data_bus_out,
	output logic tx_cell_data_bus_oe_out,
	output logic tx_data_parity_out,
	output logic tx_data_parity_oe_out
);

	// Width of the synchronised pin group: link clock, enable, address
	localparam int SYNC_W = ADDR_WIDTH + 2;

	// All state of the block
	typedef struct packed {
		lct_pkg::lct_state_type state;
		logic link_prev;
		logic en_prev;
		logic [5:0] poll_prev;
		logic [4:0] ctrl;
		logic [5:0] slave_addr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic take;
		logic en_n;
		logic en_n_oe;
		logic space;
		logic space_oe;
		logic sx;
		logic sx_oe;
		logic sop;
		logic sop_oe;
		logic [DATA_WIDTH-1:0] data;
		logic data_oe;
		logic parity;
		logic parity_oe;
		logic [15:0] cell_count;
	} lct_top_state_type;

	lct_top_state_type top_ff;
	lct_top_state_type nxt_top;

	// Synchronised pins
	logic [SYNC_W-1:0] pins_sync;
	logic link_clk_sync;
	logic enable_n_sync;
	logic [ADDR_WIDTH-1:0] poll_addr_sync;

	// Decoded config bits
	logic cfg_enable;
	logic cfg_master;
	logic cfg_byte_mode;
	logic cfg_odd;

	// Edge of the link clock seen from clk_in
	logic link_edge;

	// Access phase of an APB transfer
	logic apb_access;

	// Word to be placed on the bus at this edge
	logic [DATA_WIDTH-1:0] word_masked;

	// Link clock, enable and poll address all come from the far side
	lct_sync #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.async_in({tx_interface_clock_in, tx_enable_n_in, tx_poll_address_in}),
		.sync_out(pins_sync)
	);

	assign link_clk_sync = pins_sync[SYNC_W-1];
	assign enable_n_sync = pins_sync[SYNC_W-2];
	assign poll_addr_sync = pins_sync[ADDR_WIDTH-1:0];

	assign cfg_enable = top_ff.ctrl[lct_pkg::CTRL_ENABLE_BIT];
	assign cfg_master = top_ff.ctrl[lct_pkg::CTRL_MASTER_BIT];
	assign cfg_byte_mode = top_ff.ctrl[lct_pkg::CTRL_BYTE_MODE_BIT];
	assign cfg_odd = top_ff.ctrl[lct_pkg::CTRL_ODD_PARITY_BIT];

	// Rising edge of the synchronised link clock
	assign link_edge = link_clk_sync & ~top_ff.link_prev;

	assign apb_access = psel_in & penable_in & ~top_ff.pready;

	assign word_masked = cfg_byte_mode ? {{(DATA_WIDTH-8){1'b0}}, cell_word_in[7:0]} : cell_word_in;

	// Next-state logic for bus slave and link side
	always_comb begin
		nxt_top = top_ff;
		nxt_top.link_prev = link_clk_sync;
		// Far end moves enable and address right after its rise; use the level from before the edge
		nxt_top.en_prev = enable_n_sync;
		nxt_top.poll_prev = poll_addr_sync[lct_pkg::SLV_ADDR_WIDTH-1:0];
		nxt_top.take = 1'b0;

		// APB: one wait state, answer one cycle into the access phase
		nxt_top.pready = apb_access;
		nxt_top.pslverr = 1'b0;
		if (apb_access) begin
			nxt_top.prdata = '0;
			unique case (paddr_in)
				lct_pkg::CTRL_OFFSET: begin
					// Control bits steer the link logic
					if (pwrite_in) begin
						nxt_top.ctrl = pwdata_in[4:0];
					end
					nxt_top.prdata = {27'h000_0000, top_ff.ctrl};
				end
				lct_pkg::SLVADDR_OFFSET: begin
					// Slave poll address
					if (pwrite_in) begin
						nxt_top.slave_addr = pwdata_in[5:0];
					end
					nxt_top.prdata = {26'h000_0000, top_ff.slave_addr};
				end
				lct_pkg::STATUS_OFFSET: begin
					// Read-only link state and cell count
					nxt_top.prdata = {12'h000, top_ff.cell_count, 2'b00, top_ff.state};
				end
				default: begin
					// Unmapped address answers with an error
					nxt_top.pslverr = 1'b1;
				end
			endcase
		end

		// link outputs move only at link edge
		if (link_edge) begin
			nxt_top.sx = 1'b0;
			nxt_top.sop = 1'b0;
			if (!cfg_enable) begin
				nxt_top.state = lct_pkg::ST_IDLE;
				nxt_top.en_n = 1'b1;
				nxt_top.en_n_oe = 1'b0;
				nxt_top.space_oe = 1'b0;
				nxt_top.sx_oe = 1'b0;
				nxt_top.sop_oe = 1'b0;
				nxt_top.data_oe = 1'b0;
				nxt_top.parity_oe = 1'b0;
			end else if (cfg_master) begin
				// master mode markers and parity always driven
				nxt_top.sx_oe = 1'b1;
				nxt_top.sop_oe = 1'b1;
				nxt_top.parity_oe = 1'b1;
				nxt_top.data_oe = 1'b1;
				nxt_top.en_n_oe = 1'b1;
				nxt_top.space_oe = 1'b0;
				unique case (top_ff.state)
					lct_pkg::ST_MASTER_SEND: begin
						if (cell_valid_in) begin
							// enable stays low through the cell
							nxt_top.en_n = 1'b0;
							nxt_top.data = word_masked;
							nxt_top.take = 1'b1;
							nxt_top.sop = cell_first_in & ~cell_prepend_in;
							if (cell_last_in) begin
								nxt_top.state = lct_pkg::ST_IDLE;
								nxt_top.cell_count = top_ff.cell_count + 16'h0001;
							end
						end else begin
							// Source ran dry; pause the transfer
							nxt_top.en_n = 1'b1;
						end
					end
					default: begin
						// Idle or stale slave state: start a new block if a word waits
						nxt_top.en_n = 1'b1;
						nxt_top.state = lct_pkg::ST_IDLE;
						if (cell_valid_in) begin
							nxt_top.en_n = 1'b0;
							nxt_top.data = word_masked;
							nxt_top.take = 1'b1;
							// first block cycle carries the mark
							nxt_top.sx = 1'b1;
							nxt_top.sop = cell_first_in & ~cell_prepend_in;
							nxt_top.state = cell_last_in ? lct_pkg::ST_IDLE : lct_pkg::ST_MASTER_SEND;
							if (cell_last_in) begin
								nxt_top.cell_count = top_ff.cell_count + 16'h0001;
							end
						end
					end
				endcase
			end else begin
				// Slave mode: the far end owns the enable pin
				nxt_top.en_n_oe = 1'b0;
				nxt_top.en_n = 1'b1;
				// space reported one link cycle after match
				if (top_ff.poll_prev == top_ff.slave_addr) begin
					nxt_top.space_oe = 1'b1;
					nxt_top.space = cell_valid_in;
				end else begin
					nxt_top.space_oe = 1'b0;
				end
				unique case (top_ff.state)
					lct_pkg::ST_SLAVE_DRIVE: begin
						if (!top_ff.en_prev) begin
							// Enable still low: push the next word
							if (cell_valid_in) begin
								nxt_top.data = word_masked;
								nxt_top.take = 1'b1;
								nxt_top.sop = cell_first_in & ~cell_prepend_in;
								if (cell_last_in) begin
									nxt_top.cell_count = top_ff.cell_count + 16'h0001;
								end
							end
						end else begin
							// Enable released: let go of the bus
							nxt_top.state = lct_pkg::ST_IDLE;
							nxt_top.sx_oe = 1'b0;
							nxt_top.sop_oe = 1'b0;
							nxt_top.data_oe = 1'b0;
							nxt_top.parity_oe = 1'b0;
						end
					end
					default: begin
						nxt_top.state = lct_pkg::ST_IDLE;
						nxt_top.sx_oe = 1'b0;
						nxt_top.sop_oe = 1'b0;
						nxt_top.data_oe = 1'b0;
						nxt_top.parity_oe = 1'b0;
						if (!top_ff.en_prev) begin
							nxt_top.state = lct_pkg::ST_SLAVE_DRIVE;
							// markers and parity driven from this edge
							nxt_top.sx_oe = 1'b1;
							nxt_top.sop_oe = 1'b1;
							nxt_top.parity_oe = 1'b1;
							// data bus driven from this edge
							nxt_top.data_oe = 1'b1;
							if (cell_valid_in) begin
								nxt_top.data = word_masked;
								nxt_top.take = 1'b1;
								nxt_top.sx = 1'b1;
								nxt_top.sop = cell_first_in & ~cell_prepend_in;
								if (cell_last_in) begin
									nxt_top.cell_count = top_ff.cell_count + 16'h0001;
								end
							end
						end
					end
				endcase
			end
			// parity over all sixteen bus lines
			nxt_top.parity = (^nxt_top.data) ^ cfg_odd;
		end
	end

	// Single register stage for all state; synchronous active-low reset
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			top_ff <= '{
				state: lct_pkg::ST_IDLE,
				link_prev: 1'b0,
				en_prev: 1'b1,
				poll_prev: 6'h00,
				ctrl: lct_pkg::CTRL_RESET,
				slave_addr: lct_pkg::SLVADDR_RESET,
				prdata: 32'h0000_0000,
				pready: 1'b0,
				pslverr: 1'b0,
				take: 1'b0,
				en_n: 1'b1,
				en_n_oe: 1'b0,
				space: 1'b0,
				space_oe: 1'b0,
				sx: 1'b0,
				sx_oe: 1'b0,
				sop: 1'b0,
				sop_oe: 1'b0,
				data: '0,
				data_oe: 1'b0,
				parity: 1'b0,
				parity_oe: 1'b0,
				cell_count: 16'h0000
			};
		end else begin
			top_ff <= nxt_top;
		end
	end

	// Outputs straight from the state register
	assign prdata_out = top_ff.prdata;
	assign pready_out = top_ff.pready;
	assign pslverr_out = top_ff.pslverr;
	assign cell_take_out = top_ff.take;
	assign tx_enable_n_out = top_ff.en_n;
	assign tx_enable_n_oe_out = top_ff.en_n_oe;
	assign tx_space_available_out = top_ff.space;
	assign tx_space_available_oe_out = top_ff.space_oe;
	assign tx_transfer_start_mark_out = top_ff.sx;
	assign tx_transfer_start_mark_oe_out = top_ff.sx_oe;
	assign tx_cell_start_mark_out = top_ff.sop;
	assign tx_cell_start_mark_oe_out = top_ff.sop_oe;
	assign tx_cell_data_bus_out = top_ff.data;
	assign tx_cell_data_bus_oe_out = top_ff.data_oe;
	assign tx_data_parity_out = top_ff.parity;
	assign tx_data_parity_oe_out = top_ff.parity_oe;

endmodule

// File: lct_tx_datapath_chk.sv
// Checker for the loop transmit data path, on its top-level ports only.
// Assumes at least eight clk cycles per link clock period.
module lct_tx_datapath_chk (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic [15:0] cell_word_in,
	input wire logic cell_prepend_in,
	input wire logic cell_first_in,
	input wire logic cell_take_out,
	input wire logic tx_interface_clock_in,
	input wire logic tx_enable_n_in,
	input wire logic tx_enable_n_out,
	input wire logic tx_enable_n_oe_out,
	input wire logic tx_transfer_start_mark_out,
	input wire logic tx_cell_start_mark_out,
	input wire logic tx_cell_start_mark_oe_out,
	input wire logic [15:0] tx_cell_data_bus_out,
	input wire logic tx_cell_data_bus_oe_out,
	input wire logic tx_data_parity_out,
	input wire logic tx_data_parity_oe_out
);
	// Raw link clock samples, newest in bit 0
	logic [6:0] lk_ff;
	// A link rise lies a few clk back; loose because sync depth blurs it
	logic near_rise;

	// Shift in the link clock every cycle
	always_ff @(posedge clk_in) begin
		lk_ff <= {lk_ff[5:0], tx_interface_clock_in};
	end

	assign near_rise = |(lk_ff[5:0] & ~lk_ff[6:1]);

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// APB phases
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence

	chk_apb_one_wait: assert property (s_setup ##1 s_access |=> pready_out)
		else $error("ready late after access");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	chk_oe_group: assert property (tx_cell_data_bus_oe_out == tx_data_parity_oe_out
		&& tx_cell_data_bus_oe_out == tx_cell_start_mark_oe_out) else $error("enables split");
	chk_link_edge_only: assert property ($changed({tx_cell_data_bus_out, tx_data_parity_out,
		tx_cell_start_mark_out, tx_cell_data_bus_oe_out}) |-> near_rise) else $error("change off link edge");
	chk_take_pulse: assert property (cell_take_out |-> near_rise ##1 !cell_take_out)
		else $error("bad take pulse");
	chk_parity_sense: assert property (tx_cell_data_bus_oe_out && $past(tx_cell_data_bus_oe_out)
		|-> $stable(tx_data_parity_out ^ (^tx_cell_data_bus_out))) else $error("parity sense drift");
	chk_word_low: assert property (cell_take_out
		|-> tx_cell_data_bus_out[7:0] == $past(cell_word_in[7:0])) else $error("wrong word");
	chk_sop_first: assert property (cell_take_out
		|-> tx_cell_start_mark_out == $past(cell_first_in && !cell_prepend_in)) else $error("cell start wrong");
	chk_sx_prepend: assert property (cell_take_out && $past(cell_prepend_in)
		|-> tx_transfer_start_mark_out) else $error("start missing on prepend");
	chk_master_enable: assert property (cell_take_out && tx_enable_n_oe_out |-> !tx_enable_n_out)
		else $error("enable high in cell");
	chk_slave_start: assert property ($rose(tx_cell_data_bus_oe_out) && !tx_enable_n_oe_out
		|-> !$past(tx_enable_n_in, 5)) else $error("slave drove unasked");
endmodule

bind lct_tx_datapath lct_tx_datapath_chk u_chk (.clk_in, .rstn_in, .psel_in, .penable_in, .pready_out,
	.cell_word_in, .cell_prepend_in, .cell_first_in, .cell_take_out, .tx_interface_clock_in,
	.tx_enable_n_in, .tx_enable_n_out, .tx_enable_n_oe_out, .tx_transfer_start_mark_out,
	.tx_cell_start_mark_out, .tx_cell_start_mark_oe_out, .tx_cell_data_bus_out,
	.tx_cell_data_bus_oe_out, .tx_data_parity_out, .tx_data_parity_oe_out);

// File: lct_far_end.sv
// Far-end model: interface clock, slave-mode enable, poll address, bus pull-ups.
// Assumes the bench says when the far end wants words.
module lct_far_end (
	input wire logic go_in,
	input wire logic [11:0] poll_in,
	input wire logic [15:0] bus_in,
	input wire logic bus_oe_in,
	output logic link_clk_out,
	output logic enable_n_out,
	output logic [11:0] poll_out,
	output logic [15:0] bus_seen_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Free-running clock, phase kept off the system clock edges
	initial begin
		link_clk_out = 1'b0;
		enable_n_out = 1'b1;
		poll_out = 12'h000;
		#37;
		forever #400 link_clk_out = ~link_clk_out;
	end

	// Enable and address move just after a link rise
	// master-mode space answer not modelled: the block has no space input
	always @(posedge link_clk_out) begin
		enable_n_out <= ~go_in;
		poll_out <= poll_in;
	end

	// pulled-up lines; start mark left unwired
	assign bus_seen_out = bus_oe_in ? bus_in : 16'hffff;
endmodule

// File: tb.sv
// Self-checking bench for the loop transmit data path.
// Assumes the far-end model makes the link clock and slave enable.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, cell_take_out, tx_interface_clock_in;
	logic [15:0] cell_word_in = 16'h0000;
	logic cell_valid_in = 1'b0;
	logic cell_prepend_in = 1'b0;
	logic cell_first_in = 1'b0;
	logic cell_last_in = 1'b0;
	wire logic tx_enable_n_in;
	logic far_en_n, tx_enable_n_out, tx_enable_n_oe_out;
	logic [11:0] tx_poll_address_in;
	logic tx_space_available_out, tx_space_available_oe_out;
	logic tx_transfer_start_mark_out, tx_transfer_start_mark_oe_out;
	logic tx_cell_start_mark_out, tx_cell_start_mark_oe_out;
	logic [15:0] tx_cell_data_bus_out, bus_seen;
	logic tx_cell_data_bus_oe_out, tx_data_parity_out, tx_data_parity_oe_out;
	// Far end wants words
	logic go = 1'b0;
	logic [11:0] poll_set = 12'h000;
	// Last APB answer
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int compares = 0;
	int seed = 27;
	// Every output enable together
	wire [31:0] oe_all = {26'h000_0000, tx_enable_n_oe_out, tx_space_available_oe_out,
		tx_transfer_start_mark_oe_out, tx_cell_start_mark_oe_out, tx_cell_data_bus_oe_out, tx_data_parity_oe_out};

	// Enable pin level: design drives in master mode, far end otherwise
	assign tx_enable_n_in = tx_enable_n_oe_out ? tx_enable_n_out : far_en_n;

	always #50 clk_in = ~clk_in;

	lct_tx_datapath u_dut (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out, .cell_word_in, .cell_valid_in, .cell_prepend_in,
		.cell_first_in, .cell_last_in, .cell_take_out, .tx_interface_clock_in, .tx_enable_n_in,
		.tx_enable_n_out, .tx_enable_n_oe_out, .tx_poll_address_in, .tx_space_available_out,
		.tx_space_available_oe_out, .tx_transfer_start_mark_out, .tx_transfer_start_mark_oe_out,
		.tx_cell_start_mark_out, .tx_cell_start_mark_oe_out, .tx_cell_data_bus_out,
		.tx_cell_data_bus_oe_out, .tx_data_parity_out, .tx_data_parity_oe_out);

	lct_far_end u_far (.go_in(go), .poll_in(poll_set), .bus_in(tx_cell_data_bus_out),
		.bus_oe_in(tx_cell_data_bus_oe_out), .link_clk_out(tx_interface_clock_in),
		.enable_n_out(far_en_n), .poll_out(tx_poll_address_in), .bus_seen_out(bus_seen));

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; a cycle idles after it so no signal is set twice at once
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 20) failures++;
		@(posedge clk_in);
	endtask

	// Configure one mode and send one cell, optionally prepended
	task automatic run_cfg(input logic mst, input logic bm, input logic odd, input logic pre);
		logic [31:0] c;
		logic [5:0] sa;
		logic [15:0] w, e;
		int n;
		c = 32'h0000_0000;
		c[lct_pkg::CTRL_ENABLE_BIT] = 1'b1;
		c[lct_pkg::CTRL_MASTER_BIT] = mst;
		c[lct_pkg::CTRL_BYTE_MODE_BIT] = bm;
		c[lct_pkg::CTRL_ODD_PARITY_BIT] = odd;
		sa = 6'($random(seed));
		apb(1'b1, lct_pkg::SLVADDR_OFFSET, {26'h000_0000, sa});
		apb(1'b1, lct_pkg::CTRL_OFFSET, c);
		apb(1'b0, lct_pkg::CTRL_OFFSET, 32'h0000_0000);
		check(rd, c);
		for (int k = int'(!pre); k < 5; k++) begin
			w = 16'($random(seed));
			e = bm ? {8'h00, w[7:0]} : w;
			cell_word_in <= w;
			cell_valid_in <= 1'b1;
			cell_prepend_in <= (k == 0);
			cell_first_in <= (k == 1);
			cell_last_in <= (k == 4);
			if (!mst && k == int'(!pre)) begin
				poll_set <= {6'h2a, sa};
				repeat (24) @(posedge clk_in);
				check(32'({tx_space_available_oe_out, tx_space_available_out}), 32'h0000_0003);
				check(32'(tx_cell_data_bus_oe_out), 32'h0000_0000);
				go <= 1'b1;
			end
			n = 0;
			do begin
				@(posedge clk_in);
				n++;
			end while (cell_take_out !== 1'b1 && n < 60);
			// word and parity on the wire
			check(32'({tx_data_parity_out, bus_seen}), 32'({odd ? ~^e : ^e, e}));
			check(32'({tx_transfer_start_mark_out, tx_cell_start_mark_out, oe_all[3:0], tx_enable_n_oe_out,
				tx_enable_n_out & mst, n < 60}), 32'({k == int'(!pre), k == 1, 4'hf, mst, 1'b0, 1'b1}));
		end
		cell_valid_in <= 1'b0;
		go <= 1'b0;
		repeat (14) @(posedge clk_in);
		// idle after the cell raises enable, bus still driven
		if (mst) check(32'({tx_enable_n_out, oe_all[3:0]}), 32'h0000_001f);
		apb(1'b1, lct_pkg::CTRL_OFFSET, 32'h0000_0000);
		repeat (14) @(posedge clk_in);
		check(oe_all, 32'h0000_0000);
	endtask

	// Print verdict and stop
	task automatic complete_run();
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Main sequence: reset, register checks, every mode combination
	initial begin
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		check(oe_all, 32'h0000_0000);
		apb(1'b0, lct_pkg::CTRL_OFFSET, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		check({rd[31:1], er}, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			run_cfg(i[0], i[1], i[2], i[0] ^ i[2]);
		end
		complete_run();
	end

	// Watchdog well past the expected run length
	initial begin
		#3ms;
		failures++;
		complete_run();
	end
endmodule
